/* hdl/frac_host.sv */
// Host controller driving the flash pins for reads, writes, reset and identify.
// Assumes the flash data bus is two-way; the bench resolves the wire from data_oe_o.
`timescale 1ns/1ps
module frac_host
    import frac_pkg::*;
(
    input  wire logic                       core_clk_i,
    input  wire logic                       rst_b_i,
    input  wire logic                       req_valid_i,
    output logic                            req_ready_o,
    input  wire frac_pkg::frac_op_t         req_op_i,
    input  wire logic [frac_pkg::ADDR_W-1:0] req_addr_i,
    input  wire logic [frac_pkg::DATA_W-1:0] req_data_i,
    input  wire logic                       use_id_pin_i,
    input  wire logic                       supply_high_i,
    output logic                            rsp_valid_o,
    output logic [frac_pkg::DATA_W-1:0]     rsp_data_o,
    output logic                            rsp_refused_o,
    output logic                            id_mode_o,
    output logic                            pgm_setup_o,
    output logic [frac_pkg::ADDR_W-1:0]     flash_addr_o,
    output logic                            flash_ce_b_o,
    output logic                            flash_oe_b_o,
    output logic                            flash_we_b_o,
    output logic [frac_pkg::DATA_W-1:0]     flash_data_o,
    output logic                            flash_data_oe_o,
    input  wire logic [frac_pkg::DATA_W-1:0] flash_data_i,
    output logic                            id_voltage_address_pin_o,
    output logic                            program_supply_high_level_o
);
    import frac_pkg::*;

    // ****************************************
    // State
    // ****************************************
    typedef enum logic [2:0] {
        FRAC_IDLE,
        FRAC_RD_SETUP,
        FRAC_RD_SAMPLE,
        FRAC_WR_LOW,
        FRAC_WR_HIGH,
        FRAC_GAP
    } frac_state_t;

    frac_state_t                st_q;
    logic [DATA_W-1:0]          sync1_q;
    logic [DATA_W-1:0]          sync2_q;
    logic [DATA_W-1:0]          wdata_q;
    logic [ADDR_W-1:0]          addr_q;
    logic                       second_q;
    logic                       start;
    logic                       done;
    logic                       take;
    logic                       is_wr;
    logic                       refuse;
    logic [DATA_W-1:0]          wbyte;
    logic                       wr_is_data;
    logic                       wr_is_setup;
    logic                       wr_is_ident;
    logic                       dbl_reset;

    // ****************************************
    // Elaboration checks
    // ****************************************
    // One-cycle phases end a read before the data synchroniser has caught up
    if (PHASE_CYC < 2) begin : g_bad_phase
        $error("PHASE_CYC must be at least 2");
    end

    frac_timer #(.CYC(PHASE_CYC)) u_timer (
        .core_clk_i (core_clk_i),
        .rst_b_i    (rst_b_i),
        .start_i    (start),
        .done_o     (done)
    );

    assign req_ready_o = (st_q == FRAC_IDLE);
    assign take        = req_valid_i && req_ready_o;
    assign is_wr       = (req_op_i != FRAC_OP_READ);

    // ****************************************
    // Command decode
    // ****************************************
    // In program setup the next raw byte is program data, never a command
    assign wr_is_data  = pgm_setup_o && (req_op_i == FRAC_OP_WRITE);
    assign wr_is_setup = !pgm_setup_o && (req_op_i == FRAC_OP_WRITE)
                         && (req_data_i == CMD_PGM_SETUP);
    assign wr_is_ident = (req_op_i == FRAC_OP_IDENT)
                         || (!pgm_setup_o && (req_op_i == FRAC_OP_WRITE)
                             && (req_data_i == CMD_ID_A || req_data_i == CMD_ID_B));
    // A lone reset in setup would only program FFh, so it goes out twice
    assign dbl_reset   = (req_op_i == FRAC_OP_RESET2)
                         || ((req_op_i == FRAC_OP_RESET1) && pgm_setup_o);
    // Host-side guard: a program data write with low supply would be ignored anyway
    assign refuse      = wr_is_data && !supply_high_i;
    always_comb begin
        unique case (req_op_i)
            FRAC_OP_RESET1, FRAC_OP_RESET2: wbyte = CMD_RESET;
            FRAC_OP_IDENT:                  wbyte = CMD_ID_B;
            FRAC_OP_READCMD:                wbyte = CMD_READ;
            default:                        wbyte = req_data_i;
        endcase
    end
    assign start = (take && !refuse) || ((st_q != FRAC_IDLE) && done && (st_q != FRAC_GAP))
                   || ((st_q == FRAC_GAP) && done && second_q);

    // ****************************************
    // Data input synchroniser
    // ****************************************
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= flash_data_i;
            sync2_q <= sync1_q;
        end
    end

    // ****************************************
    // Bus sequencer
    // ****************************************
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_q     <= FRAC_IDLE;
            addr_q   <= '0;
            wdata_q  <= '0;
            second_q <= 1'b0;
        end else begin
            unique case (st_q)
                FRAC_IDLE: if (take && !refuse) begin
                    addr_q   <= req_addr_i;
                    wdata_q  <= wbyte;
                    // Double reset back to back; also safe when not in setup
                    second_q <= dbl_reset;
                    st_q     <= is_wr ? FRAC_WR_LOW : FRAC_RD_SETUP;
                end
                FRAC_RD_SETUP:  if (done) st_q <= FRAC_RD_SAMPLE;
                FRAC_RD_SAMPLE: if (done) st_q <= FRAC_GAP;
                FRAC_WR_LOW:    if (done) st_q <= FRAC_WR_HIGH;
                FRAC_WR_HIGH:   if (done) st_q <= FRAC_GAP;
                FRAC_GAP: if (done) begin
                    if (second_q) begin
                        second_q <= 1'b0;
                        st_q     <= FRAC_WR_LOW;
                    end else begin
                        st_q <= FRAC_IDLE;
                    end
                end
            endcase
        end
    end

    // ****************************************
    // Pin drive
    // ****************************************
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            flash_addr_o    <= '0;
            flash_ce_b_o    <= 1'b1;
            flash_oe_b_o    <= 1'b1;
            flash_we_b_o    <= 1'b1;
            flash_data_o    <= '0;
            flash_data_oe_o <= 1'b0;
        end else begin
            flash_addr_o    <= addr_q;
            flash_data_o    <= wdata_q;
            // Both enables low together so the command register loads
            flash_ce_b_o    <= !(st_q inside {FRAC_RD_SETUP, FRAC_RD_SAMPLE,
                                               FRAC_WR_LOW, FRAC_WR_HIGH});
            flash_we_b_o    <= (st_q != FRAC_WR_LOW);
            flash_oe_b_o    <= !(st_q inside {FRAC_RD_SETUP, FRAC_RD_SAMPLE});
            flash_data_oe_o <= (st_q inside {FRAC_WR_LOW, FRAC_WR_HIGH});
        end
    end

    // ****************************************
    // Supply and identification pins
    // ****************************************
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            id_voltage_address_pin_o    <= 1'b0;
            program_supply_high_level_o <= 1'b0;
        end else begin
            id_voltage_address_pin_o    <= use_id_pin_i;
            program_supply_high_level_o <= supply_high_i;
        end
    end

    // ****************************************
    // Tracked device mode
    // ****************************************
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            id_mode_o   <= 1'b0;
            pgm_setup_o <= 1'b0;
        end else if (take && !refuse && is_wr) begin
            // Any accepted write ends setup; a reset there goes out as two FFh bytes,
            // the first taken as program data that changes no cell
            pgm_setup_o <= wr_is_setup;
            // Identification holds until the next command write
            id_mode_o   <= wr_is_ident;
        end
    end

    // ****************************************
    // Responses
    // ****************************************
    // Code reads at ADDR_MFR / ADDR_DEV are ordinary reads; the device answers
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rsp_valid_o   <= 1'b0;
            rsp_data_o    <= '0;
            rsp_refused_o <= 1'b0;
        end else begin
            rsp_valid_o   <= ((st_q == FRAC_GAP) && done && !second_q) || (take && refuse);
            rsp_refused_o <= take && refuse;
            if (st_q == FRAC_RD_SAMPLE && done) begin
                rsp_data_o <= sync2_q;
            end
        end
    end
endmodule // frac_host

/* hdl/frac_pkg.sv */
// Constants shared by the flash reset / identification host controller.
// Assumes a byte-wide command-register flash on a parallel bus, one 250 MHz clock.
package frac_pkg;
    localparam int          ADDR_W        = 17;
    localparam int          DATA_W        = 8;
    localparam logic [7:0]  CMD_READ      = 8'h00;
    localparam logic [7:0]  CMD_RESET     = 8'hff;
    localparam logic [7:0]  CMD_PGM_SETUP = 8'h40;
    localparam logic [7:0]  CMD_ID_A      = 8'h80;
    localparam logic [7:0]  CMD_ID_B      = 8'h90;
    localparam logic [16:0] ADDR_MFR      = 17'h00000;
    localparam logic [16:0] ADDR_DEV      = 17'h00001;
    localparam int          CLK_MHZ       = 250;
    localparam int          T_PHASE_NS    = 100;
    localparam int          PHASE_CYC     = (T_PHASE_NS * CLK_MHZ + 999) / 1000;
    typedef enum logic [2:0] {
        FRAC_OP_READ,
        FRAC_OP_WRITE,
        FRAC_OP_RESET1,
        FRAC_OP_RESET2,
        FRAC_OP_IDENT,
        FRAC_OP_READCMD
    } frac_op_t;
endpackage

/* hdl/frac_timer.sv */
// Phase timer: counts a fixed number of cycles and pulses done.
// Assumes a start pulse from logic on the same clock.
`timescale 1ns/1ps
module frac_timer #(
    parameter int CYC = 25
) (
    input  wire logic core_clk_i,
    input  wire logic rst_b_i,
    input  wire logic start_i,
    output logic      done_o
);
    localparam int W = $clog2(CYC + 1);
    logic [W-1:0] cnt_q;
    if (CYC < 1) begin : g_bad_cyc
        $error("CYC must be at least 1");
    end
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_q <= '0;
        end else if (start_i) begin
            cnt_q <= W'(CYC);
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end
    assign done_o = (cnt_q == W'(1));
endmodule // frac_timer

/* tb/frac_host_properties.sv */
// Pin and response timing checks on the flash host controller.
// Bound to frac_host; one clock, async active-low reset.
`timescale 1ns/1ps
module frac_host_properties (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic use_id_pin_i,
    input wire logic req_ready_o,
    input wire logic rsp_valid_o,
    input wire logic rsp_refused_o,
    input wire logic flash_ce_b_o,
    input wire logic flash_oe_b_o,
    input wire logic flash_we_b_o,
    input wire logic flash_data_oe_o,
    input wire logic id_voltage_address_pin_o,
    input wire logic program_supply_high_level_o
);
    // ***
    // Properties
    // ***
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);
    sequence we_held;
        !flash_we_b_o [*8];
    endsequence
    chk_we_with_ce: assert property (!flash_we_b_o |-> !flash_ce_b_o && flash_data_oe_o)
        else $error("we low without ce or drive");
    chk_no_contend: assert property (!flash_oe_b_o |-> flash_we_b_o && !flash_data_oe_o)
        else $error("output enable during write");
    chk_we_width: assert property ($fell(flash_we_b_o) |-> we_held)
        else $error("write strobe too short");
    chk_busy_bus: assert property (!flash_ce_b_o |-> !req_ready_o)
        else $error("ready while bus busy");
    chk_rsp_pulse: assert property (rsp_valid_o |=> !rsp_valid_o)
        else $error("response longer than one cycle");
    chk_refuse_low: assert property (rsp_refused_o |-> rsp_valid_o && !program_supply_high_level_o)
        else $error("refusal with supply high");
    chk_refuse_quiet: assert property (rsp_refused_o |-> flash_ce_b_o && $past(flash_ce_b_o))
        else $error("bus cycle on refused write");
    chk_id_pin: assert property (1'b1 |=> id_voltage_address_pin_o == $past(use_id_pin_i))
        else $error("id pin does not follow request");
endmodule // frac_host_properties

bind frac_host frac_host_properties frac_host_properties_i (.core_clk_i, .rst_b_i, .use_id_pin_i,
    .req_ready_o, .rsp_valid_o, .rsp_refused_o, .flash_ce_b_o, .flash_oe_b_o, .flash_we_b_o,
    .flash_data_oe_o, .id_voltage_address_pin_o, .program_supply_high_level_o);

/* tb/frac_flash_model.sv */
// Behavioural command-register flash on the host's pins.
// Bench resolves the data wire; no clock, reacts to strobes.
`timescale 1ns/1ps
module frac_flash_model #(
    parameter logic [7:0] MFR_CODE = 8'h5a, // Arbitrary value
    parameter logic [7:0] DEV_CODE = 8'h3c  // Arbitrary value
) (
    input  wire logic        ce_b_i,
    input  wire logic        oe_b_i,
    input  wire logic        we_b_i,
    input  wire logic [16:0] addr_i,
    input  wire logic [7:0]  dq_i,
    input  wire logic        id_pin_i,
    input  wire logic        vpp_high_i,
    output logic      [7:0]  dq_o
);
    // ***
    // Command state and array
    // ***
    logic [7:0]  mem [16];
    logic [7:0]  last;
    logic [16:0] a_lat;
    logic [1:0]  st; // 0 read, 1 ident, 2 setup, 3 programming
    initial begin
        st = 2'd0;
        last = 8'h00;
        for (int i = 0; i < 16; i++) mem[i] = 8'ha0 | 8'(i);
    end
    always @(negedge we_b_i) if (!ce_b_i) a_lat = addr_i;
    always @(posedge we_b_i) if (!ce_b_i) begin
        if (st == 2'd2) begin
            if (vpp_high_i) mem[a_lat[3:0]] &= dq_i;
            st = 2'd3;
        end else if (dq_i == 8'hff || dq_i == 8'h00) st = 2'd0;
        else if (dq_i == 8'h80 || dq_i == 8'h90) st = 2'd1;
        else if (dq_i == 8'h40) st = 2'd2;
    end
    // Released bus shows the inverse of the last value, never a kind constant
    always @(posedge oe_b_i) last = dq_o;
    always @* begin
        if (ce_b_i || oe_b_i) dq_o = ~last;
        else if ((st == 2'd1 || id_pin_i) && addr_i[16:1] == 16'h0)
            dq_o = addr_i[0] ? DEV_CODE : MFR_CODE;
        else dq_o = mem[addr_i[3:0]];
    end
endmodule // frac_flash_model

/* tb/tb_frac_host.sv */
// Self-checking bench: frac_host driving a behavioural flash.
// Inputs change on the falling edge; 4 ns clock.
`timescale 1ns/1ps
module tb_frac_host;
    import frac_pkg::*;
    localparam logic [7:0] MFR = 8'h5a; // Arbitrary value
    localparam logic [7:0] DEV = 8'h3c; // Arbitrary value
    logic core_clk_i = 0, rst_b_i = 0, req_valid_i = 0, use_id_pin_i = 0, supply_high_i = 1;
    logic req_ready_o, rsp_valid_o, rsp_refused_o, id_mode_o, pgm_setup_o, refused;
    logic flash_ce_b_o, flash_oe_b_o, flash_we_b_o, flash_data_oe_o;
    logic id_voltage_address_pin_o, program_supply_high_level_o;
    frac_op_t req_op_i = FRAC_OP_READ;
    logic [16:0] req_addr_i = '0, flash_addr_o;
    logic [7:0] req_data_i = '0, rsp_data_o, flash_data_o, dev_dq, flash_data_i;
    int miscompares = 0, cmp_count = 0;
    int we_falls = 0;
    // Write strobes seen by the flash, to count reset bytes
    always @(negedge flash_we_b_o) we_falls++;
    assign flash_data_i = flash_data_oe_o ? flash_data_o : dev_dq;
    frac_host frac_host_i (.core_clk_i, .rst_b_i, .req_valid_i, .req_ready_o, .req_op_i,
        .req_addr_i, .req_data_i, .use_id_pin_i, .supply_high_i, .rsp_valid_o, .rsp_data_o,
        .rsp_refused_o, .id_mode_o, .pgm_setup_o, .flash_addr_o, .flash_ce_b_o, .flash_oe_b_o,
        .flash_we_b_o, .flash_data_o, .flash_data_oe_o, .flash_data_i,
        .id_voltage_address_pin_o, .program_supply_high_level_o);
    frac_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) frac_flash_model_i (.ce_b_i(flash_ce_b_o),
        .oe_b_i(flash_oe_b_o), .we_b_i(flash_we_b_o), .addr_i(flash_addr_o), .dq_i(flash_data_i),
        .id_pin_i(id_voltage_address_pin_o), .vpp_high_i(program_supply_high_level_o),
        .dq_o(dev_dq));
    initial forever #2 core_clk_i = ~core_clk_i;
    // ***
    // Helpers
    // ***
    function automatic logic [7:0] pat(input int a);
        return 8'ha0 | 8'(a);
    endfunction
    task automatic end_sim();
        $display("counts: %0d compares, %0d mismatches", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk_b(input logic [7:0] g, input logic [7:0] e, input string m);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected at %0t: %s got %h exp %h", $time, m, g, e);
        end
    endtask
    task automatic chk_f(input logic g, input logic e, input string m);
        chk_b({7'h0, g}, {7'h0, e}, m);
    endtask
    // Bounded waits: ready before raising valid, then the response pulse
    task automatic req(input frac_op_t op, input logic [16:0] a, input logic [7:0] d);
        int n;
        for (n = 0; n < 800 && req_ready_o !== 1'b1; n++) @(negedge core_clk_i);
        req_op_i = op;
        req_addr_i = a;
        req_data_i = d;
        req_valid_i = 1;
        @(negedge core_clk_i);
        req_valid_i = 0;
        for (; n < 800 && rsp_valid_o !== 1'b1; n++) @(negedge core_clk_i);
        if (n >= 800) begin
            miscompares++;
            end_sim();
        end
        refused = rsp_refused_o;
        @(negedge core_clk_i);
    endtask
    task automatic rd(input logic [16:0] a, input logic [7:0] e, input string m);
        req(FRAC_OP_READ, a, 8'h00);
        chk_b(rsp_data_o, e, m);
    endtask
    // ***
    // Scenarios
    // ***
    task automatic t_ident();
        int w0;
        rd(17'h2, pat(2), "power-up read");
        for (int k = 0; k < 2; k++) begin
            req(k ? FRAC_OP_WRITE : FRAC_OP_IDENT, 17'h0, CMD_ID_A);
            chk_f(id_mode_o, 1'b1, "id mode tracked");
            rd(17'h0, MFR, "maker code");
            rd(17'h1, DEV, "device code");
            rd(17'h1, DEV, "code persists");
            chk_f(id_mode_o, 1'b1, "id mode persists");
            w0 = we_falls;
            req(k ? FRAC_OP_RESET2 : FRAC_OP_RESET1, 17'h0, 8'h00);
            chk_b(8'(we_falls - w0), 8'(k + 1), "reset strobes");
            chk_f(id_mode_o, 1'b0, "id mode left");
            rd(17'h0, pat(0), "array after reset");
        end
        req(FRAC_OP_WRITE, 17'h0, CMD_ID_B);
        req(FRAC_OP_READCMD, 17'h0, 8'h00);
        rd(17'h0, pat(0), "read command exits");
        $display("test ident done");
    endtask
    task automatic t_pgm();
        int w0;
        req(FRAC_OP_WRITE, 17'h3, CMD_PGM_SETUP);
        chk_f(pgm_setup_o, 1'b1, "setup tracked");
        req(FRAC_OP_RESET2, 17'h3, 8'h00);
        chk_f(pgm_setup_o, 1'b0, "setup cleared");
        rd(17'h3, pat(3), "byte untouched");
        req(FRAC_OP_WRITE, 17'h6, CMD_PGM_SETUP);
        w0 = we_falls;
        req(FRAC_OP_RESET1, 17'h6, 8'h00);
        chk_b(8'(we_falls - w0), 8'h02, "setup reset doubled");
        chk_f(pgm_setup_o, 1'b0, "setup left by reset");
        rd(17'h6, pat(6), "byte kept after reset");
        req(FRAC_OP_WRITE, 17'h5, CMD_PGM_SETUP);
        req(FRAC_OP_WRITE, 17'h5, 8'h0f);
        chk_f(refused, 1'b0, "program accepted");
        req(FRAC_OP_RESET1, 17'h0, 8'h00);
        rd(17'h5, pat(5) & 8'h0f, "programmed byte");
        supply_high_i = 0;
        req(FRAC_OP_WRITE, 17'h4, CMD_PGM_SETUP);
        req(FRAC_OP_WRITE, 17'h4, 8'h00);
        chk_f(refused, 1'b1, "low supply refusal");
        req(FRAC_OP_RESET2, 17'h4, 8'h00);
        rd(17'h4, pat(4), "refused byte kept");
        supply_high_i = 1;
        $display("test program done");
    endtask
    task automatic t_idpin();
        use_id_pin_i = 1;
        rd(17'h1, DEV, "pin device code");
        rd(17'h0, MFR, "pin maker code");
        use_id_pin_i = 0;
        rd(17'h1, pat(1), "pin released");
        $display("test id pin done");
    endtask
    initial begin
        repeat (5) @(negedge core_clk_i);
        rst_b_i = 1;
        t_ident();
        t_pgm();
        t_idpin();
        end_sim();
    end
endmodule // tb_frac_host
